// ### sdram_init_and_self_refresh_tb_top.sv
// bench: both ends joined, init then self-refresh cycles.
// assumes short power-up and burst counts to keep the run brief.
`timescale 1ns/1ps
module sdram_init_and_self_refresh_tb_top;
	import sdram_seq_pkg::*;
	typedef struct packed {
		logic burst;
		logic [15:0] n_ref;
	} row_t;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic [ROW_W-1:0] mode_value = 12'h0A5;
	logic burst_refresh_en = 1'b0;
	logic sr_request = 1'b0;
	logic init_done, c_sr, busy, ready, d_sr;
	logic [MASK_W-1:0] mode_q_out;
	logic [1:0] init_refresh_seen;
	logic [15:0] n_ref = 16'h0;
	// snapshot of n_ref; keeps the counter single-driven
	logic [15:0] n_base = 16'h0;
	int errors = 0;
	int n_compared = 0;
	row_t rows [3] = '{'{1'b0, 16'h0}, '{1'b1, 16'h3}, '{1'b0, 16'h0}};
	sdram_seq_if pins ();
	sdram_seq_ctrl #(.PWRUP_CYCLES(20), .BURST_COUNT(3)) i_sdram_seq_ctrl (.clk_sys(clk_sys),
		.sys_rst(sys_rst), .pins(pins), .mode_value(mode_value),
		.burst_refresh_en(burst_refresh_en), .sr_request(sr_request),
		.init_done(init_done), .in_self_refresh(c_sr), .busy(busy));
	sdram_seq_dev i_sdram_seq_dev (.clk_sys(clk_sys), .sys_rst(sys_rst), .pins(pins),
		.ready(ready), .in_self_refresh(d_sr), .mode_q_out(mode_q_out),
		.init_refresh_seen(init_refresh_seen));
	sdram_seq_sva #(.PWRUP_CYCLES(20)) i_sdram_seq_sva (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.cke(pins.cke), .cs_n(pins.cs_n), .ras_n(pins.ras_n), .cas_n(pins.cas_n),
		.we_n(pins.we_n), .dqm(pins.dqm), .addr(pins.addr));
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	// only refreshes with cke high; the entry command is not counted
	always @(posedge clk_sys) begin
		if (pins.cke && {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} == CMD_REFRESH) begin
			n_ref <= n_ref + 16'h1;
		end
	end
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic results();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// bounded wait; which: 0 init_done, 1 ctrl self-refresh, 2 busy
	task automatic wait_for(input int which, input logic lvl);
		int k;
		k = 0;
		while ((which == 0 ? init_done : which == 1 ? c_sr : busy) !== lvl) begin
			@(negedge clk_sys);
			k++;
			if (k > 400) begin
				errors++;
				results();
			end
		end
	endtask
	initial begin
		repeat (8) @(negedge clk_sys);
		sys_rst = 1'b0;
		wait_for(0, 1'b1);
		check("dev ready", ready, 1'h1);
		check("init refreshes", init_refresh_seen, 2'h2);
		check("mode bits", mode_q_out, 4'h5);
		for (int i = 0; i < 3; i++) begin
			burst_refresh_en = rows[i].burst;
			sr_request = 1'b1;
			n_base = n_ref;
			wait_for(1, 1'b1);
			repeat (2) @(negedge clk_sys);
			check("refresh before entry", n_ref - n_base, rows[i].n_ref);
			check("dev in self-refresh", d_sr, 1'h1);
			check("cke in self-refresh", pins.cke, 1'h0);
			n_base = n_ref;
			sr_request = 1'b0;
			wait_for(1, 1'b0);
			wait_for(2, 1'b0);
			check("refresh after exit", n_ref - n_base, rows[i].n_ref);
			check("dev left self-refresh", d_sr, 1'h0);
		end
		// reset in mid self-refresh, request left high across it
		sr_request = 1'b1;
		wait_for(1, 1'b1);
		sys_rst = 1'b1;
		repeat (2) @(negedge clk_sys);
		check("cke in reset", pins.cke, 1'h0);
		check("dev in reset", d_sr, 1'h0);
		sys_rst = 1'b0;
		repeat (10) begin
			@(negedge clk_sys);
			check("early request", c_sr, 1'h0);
		end
		wait_for(0, 1'b1);
		wait_for(1, 1'b1);
		check("late request cke", pins.cke, 1'h0);
		results();
	end
endmodule

// ### sdram_seq_ctrl.sv
// controller end: power-up sequence and self-refresh entry/exit.
// assumes device end on the same clk_sys; user requests are levels.
//
// Contract
// - hold cke low, masks high, no-op
// - wait 200 us before raising cke
// - keep masks high while cke rises
// - precharge all banks after cke high
// - issue mode register set
// - issue at least two auto-refreshes
// - refresh order versus mode set free
// - self-refresh entry: cs,ras,cas low, cke low
// - device ignores inputs after entry
// - device stays while cke low
// - wait minimum row-active time before exit
// - clock stable before cke high
// - chip select high first exit cycle
// - wait exit time before real commands
// - burst refreshes around self-refresh if enabled
// - row-active minimum 40/42 ns
// - exit wait is row cycle plus setup
// - row cycle 55/60 ns
// - two cycles after mode register set
`timescale 1ns/1ps
module sdram_seq_ctrl #(
	parameter int PWRUP_CYCLES = sdram_seq_pkg::PWRUP_CYC,
	parameter int BURST_COUNT = sdram_seq_pkg::BURST_REFRESH_N
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	sdram_seq_if.ctrl pins,
	input wire logic [sdram_seq_pkg::ROW_W-1:0] mode_value,
	input wire logic burst_refresh_en,
	input wire logic sr_request,
	output logic init_done,
	output logic in_self_refresh,
	output logic busy
);
	import sdram_seq_pkg::*;
	typedef enum logic [3:0] {
		S_POWER, S_CKE_UP, S_PRE, S_PRE_WAIT, S_MRS, S_MRS_WAIT, S_REF, S_REF_WAIT,
		S_IDLE, S_BREF, S_BREF_WAIT, S_SR_ENTER, S_SR_HOLD, S_SR_EXIT, S_SR_XSR
	} cstate_t;
	typedef struct packed {
		cstate_t st;
		logic [CNT_W-1:0] wait_cnt;
		logic [CNT_W-1:0] ref_cnt;
		logic after_exit;
		logic done;
		logic cke;
		logic [3:0] cmd;
		logic [ROW_W-1:0] addr;
	} ctrl_t;
	ctrl_t s_q, s_d;
	logic wait_over;
	assign wait_over = (s_q.wait_cnt == '0);
	always_comb begin
		s_d = s_q;
		s_d.cmd = CMD_NO_OPERATION;
		s_d.addr = '0;
		if (!wait_over) begin
			s_d.wait_cnt = s_q.wait_cnt - 16'h1;
		end
		case (s_q.st)
			S_POWER: begin
				if (wait_over) begin
					s_d.st = S_CKE_UP;
					s_d.cke = 1'b1;
				end
			end
			S_CKE_UP: begin
				s_d.st = S_PRE;
				s_d.cmd = CMD_PRECHARGE;
				s_d.addr = PRECHARGE_ALL_ADDR;
				s_d.wait_cnt = CNT_W'(TRP_CYC);
			end
			S_PRE: s_d.st = S_PRE_WAIT;
			S_PRE_WAIT: begin
				if (wait_over) begin
					s_d.st = S_MRS;
					s_d.cmd = CMD_MODE_SET;
					s_d.addr = mode_value;
					s_d.wait_cnt = CNT_W'(MODE_SET_GAP - 1);
					s_d.ref_cnt = CNT_W'(INIT_REFRESH_N);
				end
			end
			S_MRS: s_d.st = S_MRS_WAIT;
			S_MRS_WAIT: begin
				if (wait_over) begin
					s_d.st = S_REF;
				end
			end
			S_REF: begin
				s_d.cmd = CMD_REFRESH;
				s_d.ref_cnt = s_q.ref_cnt - 16'h1;
				s_d.wait_cnt = CNT_W'(TRFC_CYC - 1);
				s_d.st = S_REF_WAIT;
			end
			S_REF_WAIT: begin
				if (wait_over) begin
					s_d.st = (s_q.ref_cnt == '0) ? S_IDLE : S_REF;
				end
			end
			S_IDLE: begin
				s_d.done = 1'b1;
				s_d.after_exit = 1'b0;
				if (sr_request) begin
					if (burst_refresh_en) begin
						s_d.st = S_BREF;
						s_d.ref_cnt = CNT_W'(BURST_COUNT);
					end else begin
						s_d.st = S_SR_ENTER;
					end
				end
			end
			S_BREF: begin
				s_d.cmd = CMD_REFRESH;
				s_d.ref_cnt = s_q.ref_cnt - 16'h1;
				s_d.wait_cnt = CNT_W'(TRFC_CYC - 1);
				s_d.st = S_BREF_WAIT;
			end
			S_BREF_WAIT: begin
				if (wait_over) begin
					if (s_q.ref_cnt != '0) begin
						s_d.st = S_BREF;
					end else if (s_q.after_exit) begin
						s_d.st = S_IDLE;
					end else begin
						s_d.st = S_SR_ENTER;
					end
				end
			end
			S_SR_ENTER: begin
				s_d.cmd = CMD_REFRESH;
				s_d.cke = 1'b0;
				s_d.wait_cnt = CNT_W'(TRAS_CYC);
				s_d.st = S_SR_HOLD;
			end
			S_SR_HOLD: begin
				s_d.cmd = CMD_DESELECT;
				if (wait_over && !sr_request) begin
					s_d.st = S_SR_EXIT;
				end
			end
			S_SR_EXIT: begin
				// clock runs freely here, cke raised
				s_d.cke = 1'b1;
				s_d.cmd = CMD_DESELECT;
				// exit wait, row cycle plus setup
				s_d.wait_cnt = CNT_W'(TXSR_CYC);
				s_d.st = S_SR_XSR;
			end
			S_SR_XSR: begin
				if (wait_over) begin
					s_d.after_exit = 1'b1;
					if (burst_refresh_en) begin
						s_d.st = S_BREF;
						s_d.ref_cnt = CNT_W'(BURST_COUNT);
					end else begin
						s_d.st = S_IDLE;
					end
				end
			end
			default: s_d.st = S_POWER;
		endcase
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			s_q.st <= S_POWER;
			s_q.wait_cnt <= CNT_W'(PWRUP_CYCLES);
			s_q.ref_cnt <= '0;
			s_q.after_exit <= 1'b0;
			s_q.done <= 1'b0;
			s_q.cke <= 1'b0;
			s_q.cmd <= CMD_NO_OPERATION;
			s_q.addr <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign pins.cke = s_q.cke;
	assign pins.cs_n = s_q.cmd[3];
	assign pins.ras_n = s_q.cmd[2];
	assign pins.cas_n = s_q.cmd[1];
	assign pins.we_n = s_q.cmd[0];
	// masks high throughout, no data path
	assign pins.dqm = '1;
	assign pins.addr = s_q.addr;
	assign init_done = s_q.done;
	assign in_self_refresh = (s_q.st == S_SR_HOLD);
	assign busy = (s_q.st != S_IDLE);
endmodule

// ### sdram_seq_dev.sv
// device end: tracks init and self-refresh state from the pins.
// assumes pins driven by logic on clk_sys, so no synchroniser.
`timescale 1ns/1ps
module sdram_seq_dev (
	input wire logic clk_sys,
	input wire logic sys_rst,
	sdram_seq_if.dev pins,
	output logic ready,
	output logic in_self_refresh,
	output logic [sdram_seq_pkg::MASK_W-1:0] mode_q_out,
	output logic [1:0] init_refresh_seen
);
	import sdram_seq_pkg::*;
	typedef enum logic [1:0] {D_IDLE, D_ACTIVE, D_SELF} dstate_t;
	typedef struct packed {
		dstate_t st;
		logic cke_prev;
		logic precharged;
		logic mode_set;
		logic [1:0] refreshes;
		logic rdy;
		logic [MASK_W-1:0] mode;
	} dev_t;
	dev_t s_q, s_d;
	logic [3:0] cmd;
	assign cmd = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
	always_comb begin
		s_d = s_q;
		s_d.cke_prev = pins.cke;
		case (s_q.st)
			D_IDLE: begin
				if (pins.cke) begin
					s_d.st = D_ACTIVE;
				end
			end
			D_ACTIVE: begin
				if (!pins.cke && s_q.cke_prev && cmd[3:1] == 3'h0 && pins.we_n) begin
					s_d.st = D_SELF;
				end else if (s_q.cke_prev) begin
					if (cmd == CMD_PRECHARGE) begin
						s_d.precharged = 1'b1;
					end
					if (cmd == CMD_MODE_SET) begin
						s_d.mode_set = 1'b1;
						s_d.mode = pins.addr[MASK_W-1:0];
					end
					if (cmd == CMD_REFRESH && s_q.refreshes != 2'h3) begin
						s_d.refreshes = s_q.refreshes + 2'h1;
					end
				end
			end
			D_SELF: begin
				if (pins.cke) begin
					s_d.st = D_ACTIVE;
				end
			end
			default: s_d.st = D_IDLE;
		endcase
		s_d.rdy = s_d.precharged && s_d.mode_set && (s_d.refreshes >= 2'(INIT_REFRESH_N));
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign ready = s_q.rdy;
	assign in_self_refresh = (s_q.st == D_SELF);
	assign mode_q_out = s_q.mode;
	assign init_refresh_seen = s_q.refreshes;
endmodule

// ### sdram_seq_if.sv
// pin bundle between controller and device model end.
// assumes both ends share clk_sys; no tristate pins here.
`timescale 1ns/1ps
interface sdram_seq_if;
	logic cke;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [sdram_seq_pkg::MASK_W-1:0] dqm;
	logic [sdram_seq_pkg::ROW_W-1:0] addr;
	modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, dqm, addr);
	modport dev (input cke, cs_n, ras_n, cas_n, we_n, dqm, addr);
endinterface

// ### sdram_seq_pkg.sv
// constants shared by the sequencer ends.
// assumes a 100 MHz system clock (10 ns period).
package sdram_seq_pkg;
	localparam int CLK_NS = 10;
	localparam int PWRUP_US = 200;
	localparam int PWRUP_CYC = (PWRUP_US * 1000) / CLK_NS;
	localparam int TRAS_NS = 42;
	localparam int TRAS_CYC = (TRAS_NS + CLK_NS - 1) / CLK_NS;
	localparam int TRC_NS = 60;
	localparam int TIS_NS = 2;
	localparam int TXSR_CYC = (TRC_NS + TIS_NS + CLK_NS - 1) / CLK_NS;
	localparam int MODE_SET_GAP = 2;
	localparam int INIT_REFRESH_N = 2;
	localparam int BURST_REFRESH_N = 4096;
	localparam int TRFC_CYC = (TRC_NS + CLK_NS - 1) / CLK_NS;
	localparam int TRP_NS = 18;
	localparam int TRP_CYC = (TRP_NS + CLK_NS - 1) / CLK_NS;
	localparam int ROW_W = 12;
	localparam int MASK_W = 4;
	localparam int CNT_W = 16;
	// command encoding {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_DESELECT = 4'hF;
	localparam logic [3:0] CMD_NO_OPERATION = 4'h7;
	localparam logic [3:0] CMD_PRECHARGE = 4'h2;
	localparam logic [3:0] CMD_REFRESH = 4'h1;
	localparam logic [3:0] CMD_MODE_SET = 4'h0;
	localparam logic [ROW_W-1:0] PRECHARGE_ALL_ADDR = 12'h400;
endpackage

// ### sdram_seq_sva.sv
// pin checker between controller and device ends.
// assumes shared clk_sys and async high sys_rst.
`timescale 1ns/1ps
module sdram_seq_sva #(
	parameter int PWRUP_CYCLES = sdram_seq_pkg::PWRUP_CYC
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [sdram_seq_pkg::MASK_W-1:0] dqm,
	input wire logic [sdram_seq_pkg::ROW_W-1:0] addr
);
	import sdram_seq_pkg::*;
	logic [3:0] cmd;
	logic quiet;
	logic up_q;
	logic [15:0] wait_q;
	assign cmd = {cs_n, ras_n, cas_n, we_n};
	assign quiet = cs_n || cmd == CMD_NO_OPERATION;
	// up_q: cke raised once since reset, splits init from exit
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			up_q <= 1'b0;
			wait_q <= 16'h0;
		end else begin
			up_q <= up_q | cke;
			if (!up_q && wait_q != 16'hFFFF) begin
				wait_q <= wait_q + 16'h1;
			end
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	a_masks_held: assert property (dqm == 4'hF)
		else $error("byte masks dropped");
	a_pwrup_noop: assert property (!up_q && !cke |-> cmd == CMD_NO_OPERATION)
		else $error("command before power-up end");
	a_pwrup_wait: assert property (!up_q && cke |-> wait_q >= PWRUP_CYCLES)
		else $error("cke raised too early");
	a_first_precharge: assert property (!up_q && cke |-> ##[1:4] (cmd == CMD_PRECHARGE && addr[10]))
		else $error("no precharge all after cke");
	a_mode_set_gap: assert property (cmd == CMD_MODE_SET |=> quiet)
		else $error("command inside mode set gap");
	a_entry_form: assert property (up_q && $fell(cke) |-> cmd == CMD_REFRESH)
		else $error("cke fell without entry command");
	a_sr_min_time: assert property (up_q && $fell(cke) |=> !cke [*4])
		else $error("self-refresh left too soon");
	a_exit_deselect: assert property (up_q && $rose(cke) |-> cs_n)
		else $error("exit cycle not deselected");
	a_exit_wait: assert property (up_q && $rose(cke) |=> quiet [*6])
		else $error("command inside exit wait");
endmodule
